// *** rtl/signal_distribution_control.sv ***
// register bank routing mezzanine, lvds, latch and backplane signals
`include "sig_dist_params.svh"

// Operation
// - control bit 1 drives mezzanine output-enable low-active
// - control bit 0 drives mezzanine signal format
// - status field shows mezzanine board type 0-3
// - latch bit distributed to all counters
// - buffered counters copy on latch rising edge
// - unbuffered counters halt while latch is one
// - lvds bit from user logic if select set
// - mezzanine bit from user logic if select set
// - busy output: low, high, builder busy, reserved
// - trigger one: low, high, backplane line, reserved
// - sync: low, high, backplane line, reserved
// - lvds value register drives unselected lvds bits
// - mezzanine value register drives unselected mezzanine bits
module signal_distribution_control #(
    parameter int LVDS_W = 32,
    parameter int MEZZ_W = 32,
    parameter int CNT_W  = 32
) (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_clk_en,
    input  wire sig_dist_pkg::reg_req_t   i_reg_req,
    output sig_dist_pkg::reg_rsp_t        o_reg_rsp,
    input  wire logic [1:0]               i_mezz_board_type,
    input  wire logic [LVDS_W-1:0]        i_lvds_user,
    input  wire logic [MEZZ_W-1:0]        i_mezz_user,
    input  wire logic                     i_event_builder_busy,
    input  wire logic                     i_backplane_trigger_one,
    input  wire logic                     i_backplane_sync,
    input  wire logic                     i_count_event,
    output logic                          o_mezz_output_enable_n,
    output logic                          o_mezz_format_select,
    output logic                          o_counter_latch,
    output logic [LVDS_W-1:0]             o_lvds_out,
    output logic [MEZZ_W-1:0]             o_mezz_out,
    output logic                          o_busy_out,
    output logic                          o_trigger_one,
    output logic                          o_sync,
    output logic [CNT_W-1:0]              o_buffered_count,
    output logic [CNT_W-1:0]              o_unbuffered_count
);

    ////////////////////////////////////////////////////////////////////////////
    logic                   oen;
    logic                   fmt;
    logic                   latch;
    logic [LVDS_W-1:0]      lvds_sel;
    logic [MEZZ_W-1:0]      mezz_sel;
    logic [LVDS_W-1:0]      lvds_val;
    logic [MEZZ_W-1:0]      mezz_val;
    sig_dist_pkg::src_sel_t busy_sel;
    sig_dist_pkg::src_sel_t trig_sel;
    sig_dist_pkg::src_sel_t sync_sel;

    function automatic logic pick(input sig_dist_pkg::src_sel_t sel, input logic live);
        logic r;
        r = 1'b0;
        case (sel)
            sig_dist_pkg::SRC_LOW:  r = 1'b0;
            sig_dist_pkg::SRC_HIGH: r = 1'b1;
            sig_dist_pkg::SRC_LIVE: r = live;
            default:                r = 1'b0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire        wr         = i_reg_req.wr;
    wire [15:0] addr       = i_reg_req.addr;
    wire [31:0] wd         = i_reg_req.wdata;
    wire        hit_ctrl   = addr == `SDC_OFS_CTRL;
    wire        hit_status = addr == `SDC_OFS_STATUS;
    wire        hit_latch  = addr == `SDC_OFS_LATCH;
    wire        hit_lsel   = addr == `SDC_OFS_LVDS_SEL;
    wire        hit_msel   = addr == `SDC_OFS_MEZZ_SEL;
    wire        hit_busy   = addr == `SDC_OFS_BUSY_SEL;
    wire        hit_trig   = addr == `SDC_OFS_TRIGGER_ONE_SEL;
    wire        hit_sync   = addr == `SDC_OFS_SYNC_SEL;
    wire        hit_lval   = addr == `SDC_OFS_LVDS_VAL;
    wire        hit_mval   = addr == `SDC_OFS_MEZZ_VAL;
    wire        wr_lval    = wr && hit_lval;
    wire        wr_mval    = wr && hit_mval;
    wire [1:0]  wd_src     = wd[`SDC_LSB_SRC +: 2];

    // unmapped addresses and unused bits read as zero
    wire [31:0] rd_data =
        hit_ctrl   ? {30'h0, oen, fmt} :
        hit_status ? {30'h0, i_mezz_board_type} :
        hit_latch  ? {31'h0, latch} :
        hit_lsel   ? 32'(lvds_sel) :
        hit_msel   ? 32'(mezz_sel) :
        hit_busy   ? {30'h0, busy_sel} :
        hit_trig   ? {30'h0, trig_sel} :
        hit_sync   ? {30'h0, sync_sel} :
        hit_lval   ? 32'(lvds_val) :
        hit_mval   ? 32'(mezz_val) :
        `SDC_RST_WORD;

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            oen      <= `SDC_RST_BIT;
            fmt      <= `SDC_RST_BIT;
            latch    <= `SDC_RST_BIT;
            lvds_sel <= '0;
            mezz_sel <= '0;
            lvds_val <= '0;
            mezz_val <= '0;
            busy_sel <= sig_dist_pkg::src_sel_t'(`SDC_RST_SRC);
            trig_sel <= sig_dist_pkg::src_sel_t'(`SDC_RST_SRC);
            sync_sel <= sig_dist_pkg::src_sel_t'(`SDC_RST_SRC);
        end
        else if (i_clk_en && wr)
        begin
            if (hit_ctrl)
            begin
                oen <= wd[`SDC_BIT_OEN];
                fmt <= wd[`SDC_BIT_FORMAT];
            end
            if (hit_latch) latch    <= wd[`SDC_BIT_LATCH];
            if (hit_lsel)  lvds_sel <= wd[LVDS_W-1:0];
            if (hit_msel)  mezz_sel <= wd[MEZZ_W-1:0];
            if (hit_lval)  lvds_val <= wd[LVDS_W-1:0];
            if (hit_mval)  mezz_val <= wd[MEZZ_W-1:0];
            if (hit_busy)  busy_sel <= sig_dist_pkg::src_sel_t'(wd_src);
            if (hit_trig)  trig_sel <= sig_dist_pkg::src_sel_t'(wd_src);
            if (hit_sync)  sync_sel <= sig_dist_pkg::src_sel_t'(wd_src);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port answer, one cycle after the access
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_reg_rsp <= '0;
        else if (i_clk_en)
        begin
            o_reg_rsp.ack   <= i_reg_req.wr || i_reg_req.rd;
            o_reg_rsp.rdata <= i_reg_req.rd ? rd_data : `SDC_RST_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output routing
    wire [LVDS_W-1:0] next_lvds_out = (lvds_sel & i_lvds_user) | (~lvds_sel & lvds_val);
    wire [MEZZ_W-1:0] next_mezz_out = (mezz_sel & i_mezz_user) | (~mezz_sel & mezz_val);
    wire              next_busy_out = pick(busy_sel, i_event_builder_busy);
    wire              next_trig_one = pick(trig_sel, i_backplane_trigger_one);
    wire              next_sync     = pick(sync_sel, i_backplane_sync);

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_lvds_out    <= '0;
            o_mezz_out    <= '0;
            o_busy_out    <= 1'b0;
            o_trigger_one <= 1'b0;
            o_sync        <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_lvds_out    <= next_lvds_out;
            o_mezz_out    <= next_mezz_out;
            o_busy_out    <= next_busy_out;
            o_trigger_one <= next_trig_one;
            o_sync        <= next_sync;
        end
    end

    assign o_mezz_output_enable_n = oen;
    assign o_mezz_format_select   = fmt;
    assign o_counter_latch        = latch;

    ////////////////////////////////////////////////////////////////////////////
    // the same latch feeds a buffered and an unbuffered counter
    for (genvar g = 0; g < 2; g++)
    begin : g_cnt
        logic [CNT_W-1:0] count;
        latch_counter #(
            .CNT_W    (CNT_W),
            .BUFFERED (g == 0)
        ) u_cnt (
            .i_clk_sys (i_clk_sys),
            .i_arst_n  (i_arst_n),
            .i_clk_en  (i_clk_en),
            .i_latch   (latch),
            .i_event   (i_count_event),
            .o_count   (count)
        );
    end
    assign o_buffered_count   = g_cnt[0].count;
    assign o_unbuffered_count = g_cnt[1].count;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr_ctrl;
        i_clk_en && wr && hit_ctrl;
    endsequence

    property p_oen;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_wr_ctrl |=> (o_mezz_output_enable_n == $past(wd[1]));
    endproperty
    a_oen : assert property (p_oen) else $error("output enable not taken from bit 1");

    property p_format;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_wr_ctrl |=> (o_mezz_format_select == $past(wd[0])) && (o_reg_rsp.ack);
    endproperty
    a_format : assert property (p_format) else $error("format not taken from bit 0");

    property p_status;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && i_reg_req.rd && hit_status) |=> (o_reg_rsp.rdata == {30'h0, $past(i_mezz_board_type)});
    endproperty
    a_status : assert property (p_status) else $error("board type readback wrong");

    property p_latch;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && wr && hit_latch) |=> (o_counter_latch == $past(wd[0])) ##1
            ($stable(o_counter_latch) || $past(i_clk_en && wr && hit_latch));
    endproperty
    a_latch : assert property (p_latch) else $error("latch not distributed");

    property p_lvds_user;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_clk_en |=> (((o_lvds_out ^ $past(i_lvds_user)) & $past(lvds_sel)) == '0);
    endproperty
    a_lvds_user : assert property (p_lvds_user) else $error("lvds user bit not routed");

    property p_mezz_user;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_clk_en |=> (((o_mezz_out ^ $past(i_mezz_user)) & $past(mezz_sel)) == '0);
    endproperty
    a_mezz_user : assert property (p_mezz_user) else $error("mezzanine user bit not routed");

    property p_busy;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && busy_sel != sig_dist_pkg::SRC_RESERVED) |=>
            (o_busy_out == ($past(busy_sel) == sig_dist_pkg::SRC_LIVE ? $past(i_event_builder_busy)
                                                                   : $past(busy_sel[0])));
    endproperty
    a_busy : assert property (p_busy) else $error("busy source wrong");

    property p_trig;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && trig_sel == sig_dist_pkg::SRC_LIVE) [*2] |=> (o_trigger_one == $past(i_backplane_trigger_one));
    endproperty
    a_trig : assert property (p_trig) else $error("trigger one not passed");

    property p_sync;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sync_sel == sig_dist_pkg::SRC_HIGH) |=> o_sync;
    endproperty
    a_sync : assert property (p_sync) else $error("sync not forced high");

    sequence s_wr_lval;
        (i_clk_en && wr_lval) ##1 i_clk_en;
    endsequence

    property p_lvds_val;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_wr_lval |=> (((o_lvds_out ^ $past(wd[LVDS_W-1:0], 2)) & ~$past(lvds_sel)) == '0);
    endproperty
    a_lvds_val : assert property (p_lvds_val) else $error("lvds value bit not driven");

    sequence s_wr_mval;
        (i_clk_en && wr_mval) ##1 i_clk_en;
    endsequence

    property p_mezz_val;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        s_wr_mval |=> (((o_mezz_out ^ $past(wd[MEZZ_W-1:0], 2)) & ~$past(mezz_sel)) == '0);
    endproperty
    a_mezz_val : assert property (p_mezz_val) else $error("mezzanine value bit not driven");

    property p_unmapped;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && i_reg_req.rd && addr == 16'h0024) |=> (o_reg_rsp.ack && o_reg_rsp.rdata == '0);
    endproperty
    a_unmapped : assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

// *** pkg/sig_dist_params.svh ***
// register offsets, field positions, reset values of the signal distribution block
`ifndef SIG_DIST_PARAMS_SVH
`define SIG_DIST_PARAMS_SVH

`define SDC_OFS_CTRL        16'h0000
`define SDC_OFS_STATUS      16'h0004
`define SDC_OFS_LATCH       16'h0008
`define SDC_OFS_LVDS_SEL    16'h0010
`define SDC_OFS_MEZZ_SEL    16'h0014
`define SDC_OFS_BUSY_SEL    16'h0018
`define SDC_OFS_TRIGGER_ONE_SEL   16'h001c
`define SDC_OFS_SYNC_SEL    16'h0020
`define SDC_OFS_LVDS_VAL    16'h0040
`define SDC_OFS_MEZZ_VAL    16'h0044

`define SDC_BIT_FORMAT      0
`define SDC_BIT_OEN         1
`define SDC_BIT_LATCH       0
`define SDC_LSB_TYPE        0
`define SDC_LSB_SRC         0

`define SDC_RST_WORD        32'h0000_0000
`define SDC_RST_BIT         1'h0
`define SDC_RST_SRC         2'h0

`endif

// *** pkg/sig_dist_pkg.sv ***
// types shared by the signal distribution block
package sig_dist_pkg;

    typedef enum logic [1:0]
    {
        SRC_LOW      = 2'b00,
        SRC_HIGH     = 2'b01,
        SRC_LIVE     = 2'b10,
        SRC_RESERVED = 2'b11
    } src_sel_t;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed
    {
        logic        ack;
        logic [31:0] rdata;
    } reg_rsp_t;

endpackage

// *** rtl/latch_counter.sv ***
// event counter obeying the global latch, buffered or unbuffered flavour
`include "sig_dist_params.svh"

module latch_counter #(
    parameter int CNT_W    = 32,
    parameter bit BUFFERED = 1'b1
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    input  wire logic             i_clk_en,
    input  wire logic             i_latch,
    input  wire logic             i_event,
    output logic [CNT_W-1:0]      o_count
);

    logic             latch_q;
    logic [CNT_W-1:0] running;
    logic [CNT_W-1:0] readout;

    wire latch_rise = i_latch && !latch_q;
    wire halted     = !BUFFERED && i_latch;
    wire [CNT_W-1:0] next_running = running + CNT_W'(i_event && !halted);

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            latch_q <= 1'b0;
            running <= '0;
            readout <= '0;
        end
        else if (i_clk_en)
        begin
            latch_q <= i_latch;
            running <= next_running;
            if (latch_rise)
                readout <= running;
        end
    end

    assign o_count = BUFFERED ? readout : running;

    ////////////////////////////////////////////////////////////////////////////
    property p_buffered_capture;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (BUFFERED && i_clk_en && latch_rise) |=> (o_count == $past(running));
    endproperty
    a_buffered_capture : assert property (p_buffered_capture) else $error("buffered copy missed");

    property p_buffered_no_dead_time;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (BUFFERED && i_clk_en && i_event) |=> (running == $past(running) + CNT_W'(1));
    endproperty
    a_buffered_no_dead_time : assert property (p_buffered_no_dead_time) else $error("buffered count lost");

    property p_unbuffered_halt;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!BUFFERED && i_latch) |=> (o_count == $past(o_count));
    endproperty
    a_unbuffered_halt : assert property (p_unbuffered_halt) else $error("count moved while latched");

    property p_unbuffered_resume;
        @(posedge i_clk_sys) disable iff (!i_arst_n)
        (!BUFFERED && i_clk_en && !i_latch && i_event) |=> (o_count == $past(o_count) + CNT_W'(1));
    endproperty
    a_unbuffered_resume : assert property (p_unbuffered_resume) else $error("count did not resume");

endmodule

// *** tb/mezz_backplane_model.sv ***
// far side model: mezzanine board type code and backplane trigger and sync lines
module mezz_backplane_model (
    input  wire logic       i_clk_sys,
    input  wire logic [1:0] i_type_cfg,
    input  wire logic       i_trig_cfg,
    input  wire logic       i_sync_cfg,
    output logic [1:0]      o_mezz_board_type,
    output logic            o_backplane_trigger_one,
    output logic            o_backplane_sync
);
    timeunit 1ns;
    timeprecision 1ps;

    // lines change just after an edge, as from a board timed off the same crate clock
    always @(posedge i_clk_sys)
    begin
        o_mezz_board_type       <= i_type_cfg;
        o_backplane_trigger_one <= i_trig_cfg;
        o_backplane_sync        <= i_sync_cfg;
    end
endmodule

// *** tb/test_signal_distribution_control.sv ***
// self-checking bench of the signal distribution register bank
`include "sig_dist_params.svh"

module test_signal_distribution_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   i_clk_sys = 1'b0;
    logic                   i_arst_n  = 1'b0;
    logic                   clk_en    = 1'b1;
    logic                   ev        = 1'b1;
    sig_dist_pkg::reg_req_t req       = '0;
    sig_dist_pkg::reg_rsp_t rsp;
    logic [1:0]             type_cfg  = 2'h0;
    logic [1:0]             board_type;
    logic [31:0]            lvds_user = 32'h0;
    logic [31:0]            mezz_user = 32'h0;
    logic [31:0]            lvds_out, mezz_out, buf_cnt, unb_cnt;
    logic                   busy      = 1'b0;
    logic                   trig_cfg  = 1'b0;
    logic                   sync_cfg  = 1'b0;
    logic                   bp_trig, bp_sync, oen_n, fmt, latch, busy_out, trig_out, sync_out;
    logic [31:0]            seed      = 32'h0000_7750;
    logic [31:0]            exp_q[$];
    int                     err_total = 0;
    int                     samples_checked = 0;
    int                     run       = 0;

    always #10 i_clk_sys = ~i_clk_sys;

    signal_distribution_control #(.LVDS_W(32), .MEZZ_W(32), .CNT_W(32)) dut_u (
        .i_clk_sys               (i_clk_sys),
        .i_arst_n                (i_arst_n),
        .i_clk_en                (clk_en),
        .i_reg_req               (req),
        .o_reg_rsp               (rsp),
        .i_mezz_board_type       (board_type),
        .i_lvds_user             (lvds_user),
        .i_mezz_user             (mezz_user),
        .i_event_builder_busy    (busy),
        .i_backplane_trigger_one (bp_trig),
        .i_backplane_sync        (bp_sync),
        .i_count_event           (ev),
        .o_mezz_output_enable_n  (oen_n),
        .o_mezz_format_select    (fmt),
        .o_counter_latch         (latch),
        .o_lvds_out              (lvds_out),
        .o_mezz_out              (mezz_out),
        .o_busy_out              (busy_out),
        .o_trigger_one           (trig_out),
        .o_sync                  (sync_out),
        .o_buffered_count        (buf_cnt),
        .o_unbuffered_count      (unb_cnt)
    );

    mezz_backplane_model part_u (
        .i_clk_sys               (i_clk_sys),
        .i_type_cfg              (type_cfg),
        .i_trig_cfg              (trig_cfg),
        .i_sync_cfg              (sync_cfg),
        .o_mezz_board_type       (board_type),
        .o_backplane_trigger_one (bp_trig),
        .o_backplane_sync        (bp_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic sel_exp(input logic [1:0] c, input logic live);
        return (c == 2'h1) | ((c == 2'h2) & live);
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every answer must find an access noted before it
    task automatic chk_rd(input logic [31:0] got);
        logic [31:0] exp;
        exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hdead_beef;
        chk_out(got, exp);
    endtask

    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge i_clk_sys);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        exp_q.push_back(w ? 32'h0 : e);
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge i_clk_sys);
            req <= '0;
        end
        @(negedge i_clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // running count model: the event input is held high throughout
    always @(posedge i_clk_sys)
    begin
        if (i_arst_n)
            run++;
        if (rsp.ack === 1'b1)
            chk_rd(rsp.rdata);
    end

    initial
    begin
        repeat (5000) @(posedge i_clk_sys);
        err_total++;
        stop_test();
    end

    initial
    begin
        logic [15:0] offs [9];
        logic [31:0] msk [9];
        logic [31:0] s, v, u;
        int          snap;
        offs = '{`SDC_OFS_CTRL, `SDC_OFS_LATCH, `SDC_OFS_LVDS_SEL, `SDC_OFS_MEZZ_SEL, `SDC_OFS_BUSY_SEL,
                 `SDC_OFS_TRIGGER_ONE_SEL, `SDC_OFS_SYNC_SEL, `SDC_OFS_LVDS_VAL, `SDC_OFS_MEZZ_VAL};
        msk  = '{32'h3, 32'h1, 32'hffff_ffff, 32'hffff_ffff, 32'h3, 32'h3, 32'h3, 32'hffff_ffff, 32'hffff_ffff};
        repeat (10) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        idle(1);
        chk_out({26'h0, oen_n, fmt, latch, busy_out, trig_out, sync_out}, 32'h0);
        foreach (offs[i])
            acc(1'b0, offs[i], 32'h0, 32'h0);
        // buffered copy on the rising latch, unbuffered halt while high
        acc(1'b1, `SDC_OFS_LATCH, 32'h1, 32'h0);
        idle(1);
        chk_out({31'h0, latch}, 32'h1);
        snap = run;
        idle(4);
        chk_out(buf_cnt, 32'(snap));
        chk_out(unb_cnt, 32'(snap));
        acc(1'b1, `SDC_OFS_LATCH, 32'h0, 32'h0);
        idle(4);
        chk_out(buf_cnt, 32'(snap));
        chk_out(unb_cnt, 32'(snap + 3));
        foreach (offs[i])
        begin
            v = rnd();
            acc(1'b1, offs[i], v, 32'h0);
            acc(1'b0, offs[i], 32'h0, v & msk[i]);
        end
        acc(1'b1, 16'h0024, 32'hffff_ffff, 32'h0);
        acc(1'b0, 16'h0024, 32'h0, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, `SDC_OFS_CTRL, 32'(i), 32'h0);
            idle(1);
            chk_out({30'h0, oen_n, fmt}, 32'(i));
        end
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b1, `SDC_OFS_STATUS, 32'hffff_ffff, 32'h0);
            type_cfg <= 2'(i);
            idle(2);
            acc(1'b0, `SDC_OFS_STATUS, 32'h0, 32'(i));
        end
        for (int i = 0; i < 8; i++)
        begin
            s = rnd();
            acc(1'b1, `SDC_OFS_BUSY_SEL, 32'(i % 4), 32'h0);
            busy     <= s[0];
            trig_cfg <= s[1];
            sync_cfg <= s[2];
            acc(1'b1, `SDC_OFS_TRIGGER_ONE_SEL, 32'(i % 4), 32'h0);
            acc(1'b1, `SDC_OFS_SYNC_SEL, 32'(i % 4), 32'h0);
            idle(4);
            chk_out({29'h0, busy_out, trig_out, sync_out}, {29'h0, sel_exp(2'(i % 4), s[0]),
                    sel_exp(2'(i % 4), s[1]), sel_exp(2'(i % 4), s[2])});
        end
        for (int i = 0; i < 4; i++)
        begin
            s = rnd();
            v = rnd();
            u = rnd();
            acc(1'b1, `SDC_OFS_LVDS_SEL, s, 32'h0);
            lvds_user <= u;
            mezz_user <= s;
            acc(1'b1, `SDC_OFS_LVDS_VAL, v, 32'h0);
            acc(1'b1, `SDC_OFS_MEZZ_SEL, v, 32'h0);
            acc(1'b1, `SDC_OFS_MEZZ_VAL, u, 32'h0);
            idle(3);
            chk_out(lvds_out, (s & u) | (~s & v));
            chk_out(mezz_out, (v & s) | (~v & u));
        end
        // clock enable low freezes routed outputs and counters
        @(posedge i_clk_sys);
        clk_en    <= 1'b0;
        lvds_user <= ~lvds_user;
        @(negedge i_clk_sys);
        v = lvds_out;
        u = unb_cnt;
        s = buf_cnt;
        idle(3);
        chk_out(lvds_out, v);
        chk_out(unb_cnt, u);
        chk_out(buf_cnt, s);
        @(posedge i_clk_sys);
        clk_en <= 1'b1;
        idle(2);
        chk_out(32'(exp_q.size()), 32'h0);
        stop_test();
    end
endmodule
